// [stop_mon_pkg.sv]
package stop_mon_pkg;

  // ============================================================
  // Timing
  // ============================================================
  localparam int unsigned CLOCK_HZ = 200_000_000;
  localparam int unsigned FILTER_US = 1200;
  localparam int unsigned TEST_PULSE_MS = 10;
  localparam int unsigned DISAGREE_MS = 1000;
  localparam int unsigned FILTER_CYCLES = FILTER_US * (CLOCK_HZ / 1_000_000);
  localparam int unsigned TEST_PULSE_CYCLES = TEST_PULSE_MS * (CLOCK_HZ / 1000);
  localparam int unsigned DISAGREE_CYCLES = DISAGREE_MS * (CLOCK_HZ / 1000);
  localparam int unsigned PULSE_PERIOD_CYCLES = 20 * (CLOCK_HZ / 1000);
  localparam int unsigned PULSE_LOW_CYCLES = CLOCK_HZ / 1_000_000 * 500;
  localparam int unsigned READBACK_CYCLES = CLOCK_HZ / 1_000_000 * 100;
  localparam int unsigned CNT_W = 32;

  // ============================================================
  // Configuration and position
  // ============================================================
  localparam logic MODE_PULSED = 1'h0;
  localparam logic MODE_NON_PULSED = 1'h1;
  localparam int unsigned POS_W = 8;
  localparam logic [POS_W-1:0] POS_RESET = 8'h00;

  // ============================================================
  // Carriers
  // ============================================================
  typedef struct packed {
    logic a;
    logic b;
  } chan_pair_s;

  typedef enum logic [1:0] {
    ST_INHIBIT,
    ST_RUN,
    ST_FAULT
  } stop_state_e;

endpackage : stop_mon_pkg

// [safe_stop_input_monitor.sv]
// Operation
// - Input absent or low activates torque cutoff, inhibiting power-stage pulses.
// - Inhibition released only with input high plus confirm command.
// - Stop input is always in force; no setting can disable it.
// - Low level or lost current on a channel drives the safe state.
// - Two-channel inhibition path is read back and checked.
// - A single-channel test-pulse low up to 10 ms is tolerated.
// - Channel disagreement longer than 1 s is an input fault.
// - Device drives separate pulse outputs A and B in pulsed mode.
// - Mode setting picks pulsed or non-pulsed, resets to pulsed.
// - Non-pulsed mode performs no cross-fault check on the input.
// - Position and axis number default zero; position verified after configuration load.
`timescale 1ns/100ps
`default_nettype none
module safe_stop_input_monitor
  import stop_mon_pkg::*;
#(
  parameter int unsigned FILTER_CNT = FILTER_CYCLES,
  parameter int unsigned TEST_PULSE_CNT = TEST_PULSE_CYCLES,
  parameter int unsigned DISAGREE_CNT = DISAGREE_CYCLES,
  parameter int unsigned PULSE_PERIOD_CNT = PULSE_PERIOD_CYCLES,
  parameter int unsigned PULSE_LOW_CNT = PULSE_LOW_CYCLES,
  parameter int unsigned READBACK_CNT = READBACK_CYCLES
) (
  input wire logic clock_in, // 200 MHz clock
  input wire logic rst_n_in, // Synchronous reset, low active
  input wire chan_pair_s stop_in, // Torque cutoff input channels
  input wire logic present_in, // Input wiring detected
  input wire logic mode_in, // 0 pulsed, 1 non-pulsed
  input wire logic confirm_in, // Confirm command level
  input wire logic cfg_load_in, // Configuration load strobe
  input wire logic [POS_W-1:0] cfg_pos_in, // Configured fieldbus position
  input wire logic [POS_W-1:0] cfg_axis_in, // Configured axis number
  input wire logic [POS_W-1:0] actual_pos_in, // Actual bus position
  input wire chan_pair_s readback_in, // Inhibition path readback, 1 = enabled
  output logic enable_out, // Pulse enable both channels, high releases
  output chan_pair_s path_en_out, // Per-channel power-stage supply
  output chan_pair_s test_pulse_out, // Test pulse outputs A and B
  output logic input_ok_out, // Recognised input state
  output logic fault_out, // Latched input fault
  output logic path_fault_out, // Latched readback fault
  output logic pos_fault_out, // Position mismatch
  output logic [POS_W-1:0] pos_out, // Held fieldbus position
  output logic [POS_W-1:0] axis_out // Held axis number
);

  // ============================================================
  // State
  // ============================================================
  typedef struct packed {
    stop_state_e st;
    chan_pair_s filt;
    logic [CNT_W-1:0] flt_a;
    logic [CNT_W-1:0] flt_b;
    logic [CNT_W-1:0] low_a;
    logic [CNT_W-1:0] low_b;
    logic [CNT_W-1:0] dis;
    logic [CNT_W-1:0] pcnt;
    logic [CNT_W-1:0] rb;
    logic input_ok;
    logic fault;
    logic path_fault;
    logic pos_fault;
    logic conf_prev;
    logic mode;
    logic enable;
    chan_pair_s tp;
    logic [POS_W-1:0] pos;
    logic [POS_W-1:0] axis;
  } state_s;

  state_s s_q;
  state_s s_d;

  // ============================================================
  // Helpers
  // ============================================================
  // Counts saturate, so a condition that sticks never wraps back to zero.
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    logic [CNT_W-1:0] r;
    if (v == {CNT_W{1'b1}}) begin
      r = v;
    end else begin
      r = v + 1'b1;
    end
    return r;
  endfunction : sat_inc

  function automatic logic reached(input logic [CNT_W-1:0] cnt, input int unsigned lim);
    return cnt >= CNT_W'(lim);
  endfunction : reached

  function automatic logic beyond(input logic [CNT_W-1:0] cnt, input int unsigned lim);
    return cnt > CNT_W'(lim);
  endfunction : beyond

  function automatic logic is_pulsed(input logic m);
    return m == MODE_PULSED;
  endfunction : is_pulsed

  // ============================================================
  // Working signals
  // ============================================================
  logic pulsed_now;
  logic pulsed_prev;
  logic tp_a_low;
  logic tp_b_low;
  logic both_low;
  logic a_long_low;
  logic b_long_low;
  logic raw_ok;
  logic disagree_fault;
  logic cross_fault;
  logic fault_set;
  logic path_mismatch;
  logic path_set;
  logic confirm_rise;
  logic chans_agree;
  logic release_ok;
  logic trip;

  // ============================================================
  // Next state
  // ============================================================
  always_comb begin
    s_d = s_q;

    // Mode is taken every cycle; there is no inactive choice.
    s_d.mode = mode_in;
    pulsed_now = is_pulsed(mode_in);
    pulsed_prev = is_pulsed(s_q.mode);

    // Interference filter, channel A.
    if (stop_in.a == s_q.filt.a) begin
      s_d.flt_a = '0;
    end else if (reached(s_q.flt_a, FILTER_CNT)) begin
      s_d.filt.a = stop_in.a;
      s_d.flt_a = '0;
    end else begin
      s_d.flt_a = sat_inc(s_q.flt_a);
    end

    // Interference filter, channel B.
    if (stop_in.b == s_q.filt.b) begin
      s_d.flt_b = '0;
    end else if (reached(s_q.flt_b, FILTER_CNT)) begin
      s_d.filt.b = stop_in.b;
      s_d.flt_b = '0;
    end else begin
      s_d.flt_b = sat_inc(s_q.flt_b);
    end

    // Test pulse period counter.
    if (reached(s_q.pcnt, PULSE_PERIOD_CNT - 1)) begin
      s_d.pcnt = '0;
    end else begin
      s_d.pcnt = sat_inc(s_q.pcnt);
    end

    // The B low sits half a period after the A low, so both are never low together.
    tp_a_low = !reached(s_q.pcnt, PULSE_LOW_CNT);
    tp_b_low = reached(s_q.pcnt, PULSE_PERIOD_CNT / 2) &&
               !reached(s_q.pcnt, PULSE_PERIOD_CNT / 2 + PULSE_LOW_CNT);
    if (pulsed_now) begin
      s_d.tp.a = !tp_a_low;
      s_d.tp.b = !tp_b_low;
    end else begin
      s_d.tp.a = 1'b1;
      s_d.tp.b = 1'b1;
    end

    // Low time of each filtered channel.
    if (s_q.filt.a) begin
      s_d.low_a = '0;
    end else begin
      s_d.low_a = sat_inc(s_q.low_a);
    end
    if (s_q.filt.b) begin
      s_d.low_b = '0;
    end else begin
      s_d.low_b = sat_inc(s_q.low_b);
    end

    // Recognised input: a single-channel low is a test pulse until it lasts too long.
    both_low = !s_q.filt.a && !s_q.filt.b;
    a_long_low = beyond(s_q.low_a, TEST_PULSE_CNT);
    b_long_low = beyond(s_q.low_b, TEST_PULSE_CNT);
    raw_ok = present_in && !both_low && !a_long_low && !b_long_low;
    s_d.input_ok = raw_ok;

    // Channel disagreement timer.
    if (s_q.filt.a != s_q.filt.b) begin
      s_d.dis = sat_inc(s_q.dis);
    end else begin
      s_d.dis = '0;
    end
    disagree_fault = beyond(s_q.dis, DISAGREE_CNT);

    // Cross-fault: a raw channel high while its own pulse output is low.
    // Checked only while the pin and the register both say pulsed, because the
    // pulse outputs lag a mode change by one cycle.
    cross_fault = pulsed_now && pulsed_prev &&
                  ((stop_in.a && !s_q.tp.a) || (stop_in.b && !s_q.tp.b));
    fault_set = disagree_fault || cross_fault;
    if (fault_set) begin
      s_d.fault = 1'b1;
    end

    // Readback: both supply paths must follow the enable within READBACK_CNT.
    path_mismatch = (readback_in.a != s_q.enable) || (readback_in.b != s_q.enable);
    path_set = path_mismatch && reached(s_q.rb, READBACK_CNT);
    if (path_mismatch) begin
      s_d.rb = sat_inc(s_q.rb);
    end else begin
      s_d.rb = '0;
    end
    if (path_set) begin
      s_d.path_fault = 1'b1;
    end

    // Configuration load and position verification.
    if (cfg_load_in) begin
      s_d.pos = cfg_pos_in;
      s_d.axis = cfg_axis_in;
      s_d.pos_fault = (cfg_pos_in != actual_pos_in);
    end

    // Confirm acts on its rising edge only, so a held level cannot re-release.
    confirm_rise = confirm_in && !s_q.conf_prev;
    s_d.conf_prev = confirm_in;
    chans_agree = (s_q.filt.a == s_q.filt.b);
    release_ok = confirm_rise && s_q.input_ok && !s_q.pos_fault;
    trip = !s_q.input_ok || s_q.fault || s_q.path_fault || s_q.pos_fault;

    unique case (s_q.st)
      ST_RUN: begin
        if (trip) begin
          s_d.st = ST_INHIBIT;
        end
      end
      ST_INHIBIT: begin
        if (s_q.fault || s_q.path_fault) begin
          s_d.st = ST_FAULT;
        end else if (release_ok) begin
          s_d.st = ST_RUN;
        end
      end
      ST_FAULT: begin
        // A fault raised in the same cycle as the clear wins.
        if (confirm_rise && chans_agree) begin
          if (!fault_set) begin
            s_d.fault = 1'b0;
          end
          if (!path_set) begin
            s_d.path_fault = 1'b0;
          end
          if (!fault_set && !path_set) begin
            s_d.st = ST_INHIBIT;
          end
        end
      end
      default: begin
        s_d.st = ST_INHIBIT;
      end
    endcase

    // Enable follows the run state one cycle late but drops with it at once.
    s_d.enable = (s_q.st == ST_RUN) && (s_d.st == ST_RUN);
  end

  // ============================================================
  // Registers
  // ============================================================
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
      s_q.st <= ST_INHIBIT;
      s_q.mode <= MODE_PULSED;
      s_q.tp <= '{a: 1'b1, b: 1'b1};
      s_q.pos <= POS_RESET;
      s_q.axis <= POS_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ============================================================
  // Outputs
  // ============================================================
  assign enable_out = s_q.enable;
  assign path_en_out = '{a: s_q.enable, b: s_q.enable};
  assign test_pulse_out = s_q.tp;
  assign input_ok_out = s_q.input_ok;
  assign fault_out = s_q.fault;
  assign path_fault_out = s_q.path_fault;
  assign pos_fault_out = s_q.pos_fault;
  assign pos_out = s_q.pos;
  assign axis_out = s_q.axis;

endmodule : safe_stop_input_monitor
`default_nettype wire

// [stop_mon_properties.sv]
`timescale 1ns/100ps
`default_nettype none
module stop_mon_props
  import stop_mon_pkg::*;
(
  input wire logic clock_in, // Clock
  input wire logic rst_n_in, // Reset
  input wire logic present_in, // Wired
  input wire logic mode_in, // Mode
  input wire logic confirm_in, // Confirm
  input wire logic cfg_load_in, // Load
  input wire logic [POS_W-1:0] cfg_pos_in, // Position
  input wire logic [POS_W-1:0] actual_pos_in, // Actual
  input wire chan_pair_s readback_in, // Readback
  input wire logic enable_out, // Enable
  input wire chan_pair_s path_en_out, // Paths
  input wire chan_pair_s test_pulse_out, // Pulses
  input wire logic input_ok_out, // Input state
  input wire logic fault_out, // Fault
  input wire logic path_fault_out, // Path fault
  input wire logic pos_fault_out, // Position fault
  input wire logic [POS_W-1:0] pos_out // Position
);
  // ==========
  // Properties
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence s_drop;
    input_ok_out ##1 !input_ok_out;
  endsequence
  sequence s_mism;
    (path_en_out != readback_in) [*5];
  endsequence
  a_lost_inhibit: assert property (s_drop |-> ##2 !enable_out) else $error("enable held");
  a_absent_low: assert property (!present_in |-> ##[1:3] !input_ok_out) else $error("absent");
  a_needs_confirm: assert property ($rose(enable_out) |-> $past(confirm_in, 2)
    || $past(confirm_in, 3)) else $error("release without confirm");
  a_fault_blocks: assert property (fault_out || path_fault_out |-> ##2 !enable_out)
    else $error("fault not inhibiting");
  a_readback_check: assert property (s_mism |-> ##[0:2] path_fault_out) else $error("rb");
  a_pulse_const: assert property (mode_in [*2] |-> test_pulse_out == 2'h3) else $error("tp");
  a_pulse_offset: assert property (!mode_in |-> test_pulse_out != 2'h0) else $error("tp");
  a_fault_sticky: assert property ($fell(fault_out) |-> $past(confirm_in)
    || $past(confirm_in, 2)) else $error("fault cleared without confirm");
  a_pos_check: assert property (cfg_load_in |=> pos_out == $past(cfg_pos_in)
    && pos_fault_out == ($past(cfg_pos_in) != $past(actual_pos_in))) else $error("pos");
endmodule : stop_mon_props
bind safe_stop_input_monitor stop_mon_props i_props (.clock_in(clock_in), .rst_n_in(rst_n_in),
  .present_in(present_in), .mode_in(mode_in), .confirm_in(confirm_in), .cfg_load_in(cfg_load_in),
  .cfg_pos_in(cfg_pos_in), .actual_pos_in(actual_pos_in), .readback_in(readback_in),
  .enable_out(enable_out), .path_en_out(path_en_out), .test_pulse_out(test_pulse_out),
  .input_ok_out(input_ok_out), .fault_out(fault_out), .path_fault_out(path_fault_out),
  .pos_fault_out(pos_fault_out), .pos_out(pos_out));
`default_nettype wire

// [stop_switch_chain.sv]
`timescale 1ns/100ps
`default_nettype none
module stop_switch_chain
  import stop_mon_pkg::*;
(
  input wire logic clock_in, // Clock
  input wire chan_pair_s pulse_in, // Device test pulses
  input wire chan_pair_s contact_in, // Contact or safe output levels
  input wire logic foreign_in, // Safe output drives the input
  input wire chan_pair_s path_en_in, // Device path enables
  input wire logic stuck_in, // Supply fails to switch off
  output logic [1:0] stop_out, // Input channel levels
  output chan_pair_s readback_out // Path readback
);
  // A closed contact passes only its own channel's pulse, so wiring faults show.
  assign stop_out = foreign_in ? contact_in : pulse_in & contact_in;
  always_ff @(posedge clock_in) begin
    readback_out <= stuck_in ? 2'h3 : path_en_in;
  end
endmodule : stop_switch_chain
`default_nettype wire

// [test_safe_stop_input_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module test_safe_stop_input_monitor;
  import stop_mon_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, present = 1'b1, mode = 1'b0, confirm = 1'b0;
  logic load = 1'b0, stuck = 1'b0, enable, ok, fault, pfault, posf;
  logic [7:0] pos = 8'h00, axis = 8'h00, actual = 8'h00, pos_o, axis_o;
  logic [1:0] stop;
  chan_pair_s contact = 2'h3, rb, path, pulse;
  logic [4:0] rows [5] = '{5'h0F, 5'h02, 5'h1F, 5'h1C, 5'h0F};
  int err_count = 0, n_checks = 0;
  always #2.5 clock = ~clock;
  safe_stop_input_monitor #(.FILTER_CNT(4), .TEST_PULSE_CNT(20), .DISAGREE_CNT(60),
    .PULSE_PERIOD_CNT(40), .PULSE_LOW_CNT(4), .READBACK_CNT(3)) i_dut (.clock_in(clock),
    .rst_n_in(rst_n), .stop_in(stop), .present_in(present), .mode_in(mode), .confirm_in(confirm),
    .cfg_load_in(load), .cfg_pos_in(pos), .cfg_axis_in(axis), .actual_pos_in(actual),
    .readback_in(rb), .enable_out(enable), .path_en_out(path), .test_pulse_out(pulse),
    .input_ok_out(ok), .fault_out(fault), .path_fault_out(pfault), .pos_fault_out(posf),
    .pos_out(pos_o), .axis_out(axis_o));
  stop_switch_chain i_chain (.clock_in(clock), .pulse_in(pulse), .contact_in(contact),
    .foreign_in(mode), .path_en_in(path), .stuck_in(stuck), .stop_out(stop), .readback_out(rb));
  // ==========
  // Tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task automatic wait_ok(input logic v);
    int n;
    repeat (2) @(posedge clock);
    for (n = 0; n < 400 && ok !== v; n++) @(posedge clock);
    if (n == 400) begin
      chk(ok, v);
      give_verdict();
    end
  endtask : wait_ok
  task automatic press;
    confirm <= 1'b1;
    @(posedge clock);
    confirm <= 1'b0;
    repeat (5) @(posedge clock);
  endtask : press
  task automatic load_cfg(input logic [7:0] p, input logic [7:0] a, input logic [7:0] x);
    {pos, actual, axis, load} <= {p, a, x, 1'b1};
    @(posedge clock);
    load <= 1'b0;
    repeat (2) @(posedge clock);
  endtask : load_cfg
  // ==========
  // Sequence
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk(enable, 8'h00);
    chk(pulse, 8'h03);
    chk(pos_o, 8'h00);
    chk(axis_o, 8'h00);
    foreach (rows[i]) begin
      {mode, contact, present} <= rows[i][4:1];
      wait_ok(rows[i][0]);
      press();
      chk(enable, rows[i][0]);
      chk(path, {2{rows[i][0]}});
      $display("Row %0d done", i);
    end
    contact <= 2'h0;
    repeat (2) @(posedge clock);
    contact <= 2'h3;
    repeat (8) @(posedge clock);
    chk(enable, 8'h01);
    mode <= 1'b1;
    contact <= 2'h1;
    repeat (12) @(posedge clock);
    contact <= 2'h3;
    repeat (5) @(posedge clock);
    chk(enable, 8'h01);
    contact <= 2'h1;
    repeat (100) @(posedge clock);
    chk(fault, 8'h01);
    chk(enable, 8'h00);
    contact <= 2'h3;
    wait_ok(1'b1);
    press();
    chk(fault, 8'h00);
    chk(enable, 8'h00);
    load_cfg(8'h06, 8'h05, 8'h0A);
    chk(posf, 8'h01);
    chk(axis_o, 8'h0A);
    press();
    chk(enable, 8'h00);
    load_cfg(8'h05, 8'h05, 8'h03);
    chk(pos_o, 8'h05);
    chk(axis_o, 8'h03);
    press();
    chk(enable, 8'h01);
    $display("Hand tests done");
    stuck <= 1'b1;
    contact <= 2'h0;
    wait_ok(1'b0);
    repeat (10) @(posedge clock);
    chk(pfault, 8'h01);
    chk(enable, 8'h00);
    give_verdict();
  end
endmodule : test_safe_stop_input_monitor
`default_nettype wire
